/* File: sas_pkg.sv */
// Purpose: shared constants for the converter sequencer
// Assumes: ref_clk is the instruction-cycle clock
// Notes: field widths follow the control bit layout
package sas_pkg;
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned BUF_WORDS = 16;
  localparam int unsigned HALF_WORDS = 8;
  localparam int unsigned RES_W = 12;
  localparam int unsigned BUS_W = 16;
  localparam int unsigned CONV_TADS = 14;
  localparam int unsigned SAMPLES_PER_IRQ_LSB = 2;
  localparam int unsigned SAMPLES_PER_IRQ_MSB = 5;
  localparam int unsigned SCAN_BIT = 10;
  localparam logic [2:0] TRIG_SW = 3'h0;
  localparam logic [2:0] TRIG_AUTO = 3'h7;
  localparam logic [1:0] FMT_INT = 2'h0;
  localparam logic [1:0] FMT_SINT = 2'h1;
  localparam logic [1:0] FMT_FRAC = 2'h2;
  localparam logic [1:0] FMT_SFRAC = 2'h3;
  typedef enum logic [1:0] {
    SAS_IDLE = 2'b00,
    SAS_SAMPLE = 2'b01,
    SAS_CONVERT = 2'b11
  } sas_state_t;
endpackage

/* File: sas_sequencer.sv */
// Purpose: sample/convert sequencer, result buffer and flags for a 12-bit sar converter
// Assumes: all controls come from logic on ref_clk; triggers and core data too
// Notes: conversion clock is a tick derived from ref_clk or a synchronised rc tick
`timescale 1ns/1ns
module sas_sequencer
  import sas_pkg::*;
#(
  parameter int unsigned CH_N = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic module_on,
  input wire logic sample_ctl_set, // one-cycle software set of sample_ctl
  input wire logic sample_ctl_clr, // one-cycle software clear of sample_ctl
  input wire logic auto_sample_enable,
  input wire logic [2:0] trigger_source_sel,
  input wire logic [3:0] ext_trig, // sources 1..3 used, index 0 unused
  input wire logic [4:0] auto_sample_time,
  input wire logic [15:0] control_reg_two, // samples_per_irq, scan_first_input_set etc.
  input wire logic split_buffer_sel,
  input wire logic alternate_mux_sel,
  input wire logic [5:0] conv_clock_div,
  input wire logic rc_clock_sel,
  input wire logic rc_tick_pin, // internal rc oscillator, asynchronous
  input wire logic [15:0] scan_select_reg,
  input wire logic [3:0] first_input_set,
  input wire logic [3:0] second_input_set,
  input wire logic [1:0] output_format_sel,
  input wire logic done_clr, // software clear of done
  input wire logic irq_clr, // software clear of conv_irq_flag
  input wire logic [RES_W-1:0] core_result, // converter core answer
  input wire logic [3:0] rd_addr,
  output logic [BUS_W-1:0] rd_data,
  output logic [3:0] mux_sel, // positive input to the analog mux
  output logic hold_sample, // sample switch closed
  output logic conv_start, // one-cycle pulse to the core
  output logic sample_ctl,
  output logic conv_busy,
  output logic done,
  output logic conv_irq_flag,
  output logic buf_half // half being written when split
);
  // state and storage
  sas_state_t state_r;
  logic [RES_W-1:0] result_buffer [BUF_WORDS]; // read only from software side
  logic [6:0] div_cnt_r; // half-cycle counter, counts two per ref_clk
  logic tad_tick; // one conversion clock period elapsed
  logic rc_s1_r, rc_s2_r, rc_s3_r;
  logic [4:0] sample_ctl_cnt_r;
  logic [3:0] tad_cnt_r;
  logic [3:0] smp_cnt_r; // samples since last interrupt
  logic [3:0] wptr_r;
  logic alt_r; // next sequence uses the second set
  logic [3:0] scan_ch_r;
  logic [3:0] samples_per_irq;
  logic scan_on;
  logic trig; // conversion trigger from the chosen source

  assign samples_per_irq = control_reg_two[SAMPLES_PER_IRQ_MSB:SAMPLES_PER_IRQ_LSB];
  assign scan_on = control_reg_two[SCAN_BIT];

  // conversion clock: period = instr_cycle * (div+1)/2; counting in half
  // cycles keeps even dividers exact on average
  always_ff @(posedge ref_clk) begin
    if (rst || !module_on) begin
      div_cnt_r <= 7'h00;
    end else if (!rc_clock_sel) begin
      if (conv_clock_div == 6'h00) begin
        // a half-cycle tad cannot beat ref_clk: tick every cycle, hold the count
        div_cnt_r <= 7'h00;
      end else if (div_cnt_r + 7'h02 >= {1'b0, conv_clock_div} + 7'h01) begin
        div_cnt_r <= div_cnt_r + 7'h02 - ({1'b0, conv_clock_div} + 7'h01);
      end else begin
        div_cnt_r <= div_cnt_r + 7'h02;
      end
    end
  end

  // rc source synchronised, rising edge gives the tick
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rc_s1_r <= 1'b0;
      rc_s2_r <= 1'b0;
      rc_s3_r <= 1'b0;
    end else begin
      rc_s1_r <= rc_tick_pin;
      rc_s2_r <= rc_s1_r;
      rc_s3_r <= rc_s2_r;
    end
  end

  // tick selection
  always_comb begin
    if (rc_clock_sel) begin
      tad_tick = rc_s2_r & ~rc_s3_r;
    end else begin
      tad_tick = (div_cnt_r + 7'h02 >= {1'b0, conv_clock_div} + 7'h01);
    end
  end

  // conversion trigger choice
  always_comb begin
    unique case (trigger_source_sel)
      TRIG_SW: trig = sample_ctl_clr;
      TRIG_AUTO: trig = tad_tick && (sample_ctl_cnt_r + 5'h01 >= auto_sample_time);
      3'h1: trig = ext_trig[1];
      3'h2: trig = ext_trig[2];
      3'h3: trig = ext_trig[3];
      default: trig = 1'b0;
    endcase
  end

  // main sequencing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= SAS_IDLE;
      sample_ctl <= 1'b0;
      hold_sample <= 1'b0;
      conv_start <= 1'b0;
      conv_busy <= 1'b0;
      sample_ctl_cnt_r <= 5'h00;
      tad_cnt_r <= 4'h0;
    end else begin
      conv_start <= 1'b0;
      if (!module_on) begin
        // abort wins over any start in the same cycle
        state_r <= SAS_IDLE;
        sample_ctl <= 1'b0;
        hold_sample <= 1'b0;
        conv_busy <= 1'b0;
      end else begin
        unique case (state_r)
          SAS_IDLE: begin
            if (sample_ctl_set || auto_sample_enable) begin
              state_r <= SAS_SAMPLE;
              sample_ctl <= 1'b1;
              hold_sample <= 1'b1;
              sample_ctl_cnt_r <= 5'h00;
            end
          end
          SAS_SAMPLE: begin
            if (tad_tick && sample_ctl_cnt_r != 5'h1f) begin
              sample_ctl_cnt_r <= sample_ctl_cnt_r + 5'h01;
            end
            if (trig) begin
              state_r <= SAS_CONVERT;
              sample_ctl <= 1'b0;
              hold_sample <= 1'b0;
              conv_start <= 1'b1;
              conv_busy <= 1'b1;
              tad_cnt_r <= 4'h0;
            end else if (sample_ctl_clr) begin
              sample_ctl <= 1'b0; // non-software source: stays sampling
            end else if (sample_ctl_set) begin
              sample_ctl <= 1'b1; // software may raise it again while sampling
            end
          end
          SAS_CONVERT: begin
            if (tad_tick) begin
              if (tad_cnt_r == 4'(CONV_TADS - 1)) begin
                conv_busy <= 1'b0;
                if (auto_sample_enable) begin
                  state_r <= SAS_SAMPLE;
                  sample_ctl <= 1'b1;
                  hold_sample <= 1'b1;
                  sample_ctl_cnt_r <= 5'h00;
                end else begin
                  state_r <= SAS_IDLE;
                end
              end else begin
                tad_cnt_r <= tad_cnt_r + 4'h1;
              end
            end
          end
          default: state_r <= SAS_IDLE;
        endcase
      end
    end
  end

  // a conversion completes in this cycle
  logic conv_end;
  logic irq_evt;
  assign conv_end = module_on && state_r == SAS_CONVERT && tad_tick &&
    tad_cnt_r == 4'(CONV_TADS - 1);
  assign irq_evt = conv_end && smp_cnt_r == samples_per_irq;

  // result store, no partial write on abort
  always_ff @(posedge ref_clk) begin
    if (conv_end) begin
      result_buffer[wptr_r] <= core_result;
    end
  end

  // write pointer, sample count and buffer half
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wptr_r <= 4'h0;
      smp_cnt_r <= 4'h0;
      buf_half <= 1'b0;
    end else if (!module_on) begin
      // switching off restarts the sequence so scan and count stay aligned
      wptr_r <= 4'h0;
      smp_cnt_r <= 4'h0;
      buf_half <= 1'b0;
    end else if (conv_end) begin
      if (irq_evt) begin
        smp_cnt_r <= 4'h0;
        if (split_buffer_sel) begin
          buf_half <= ~buf_half;
          wptr_r <= {~buf_half, 3'h0};
        end else begin
          wptr_r <= 4'h0;
        end
      end else begin
        smp_cnt_r <= smp_cnt_r + 4'h1;
        wptr_r <= wptr_r + 4'h1;
      end
    end
  end

  // done and interrupt flags; a set beats a same-cycle clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done <= 1'b0;
      conv_irq_flag <= 1'b0;
    end else begin
      if (irq_evt) begin
        done <= 1'b1;
      end else if (done_clr) begin
        done <= 1'b0;
      end
      if (irq_evt) begin
        conv_irq_flag <= 1'b1;
      end else if (irq_clr) begin
        conv_irq_flag <= 1'b0;
      end
    end
  end

  // next selected scan input above the current one, wraps to lowest
  function automatic logic [3:0] scan_next(input logic [3:0] cur, input logic [15:0] sel);
    logic [3:0] res;
    logic found;
    res = cur;
    found = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (sel[i] && 5'(i) > {1'b0, cur}) begin
        res = 4'(i);
        found = 1'b1;
      end
    end
    if (!found) begin
      for (int i = 15; i >= 0; i--) begin
        if (sel[i]) begin
          res = 4'(i);
        end
      end
    end
    return res;
  endfunction

  // lowest selected scan input
  function automatic logic [3:0] scan_first(input logic [15:0] sel);
    logic [3:0] res;
    res = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (sel[i]) begin
        res = 4'(i);
      end
    end
    return res;
  endfunction

  // input set alternation and scan position
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alt_r <= 1'b0;
      scan_ch_r <= 4'h0;
    end else if (!module_on || irq_evt) begin
      alt_r <= 1'b0;
      scan_ch_r <= scan_first(scan_select_reg);
    end else if (conv_end) begin
      alt_r <= alternate_mux_sel ? ~alt_r : 1'b0;
      if (!(alternate_mux_sel && !alt_r)) begin
        scan_ch_r <= scan_next(scan_ch_r, scan_select_reg);
      end
    end
  end

  // mux select toward the analog side
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mux_sel <= 4'h0;
    end else if (alternate_mux_sel && alt_r) begin
      mux_sel <= second_input_set;
    end else if (scan_on) begin
      mux_sel <= scan_ch_r;
    end else begin
      mux_sel <= first_input_set;
    end
  end

  // read port formatting, registered for a clean output
  logic [RES_W-1:0] rd_word;
  assign rd_word = result_buffer[rd_addr];
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data <= 16'h0000;
    end else begin
      unique case (output_format_sel)
        FMT_INT: rd_data <= {4'h0, rd_word};
        FMT_SINT: rd_data <= {{4{rd_word[RES_W-1]}}, rd_word};
        FMT_FRAC: rd_data <= {rd_word, 4'h0};
        FMT_SFRAC: rd_data <= {rd_word, 4'h0};
      endcase
    end
  end
endmodule // sas_sequencer

/* File: sas_core_model.sv */
// Purpose: model of the analog mux, hold stage and converter core
// Assumes: the code is taken from mux_sel when conv_start is seen
// Notes: outside a conversion the bus shows the inverse, never a stale code
`timescale 1ns/1ns
module sas_core_model (
  input wire logic ref_clk,
  input wire logic conv_start,
  input wire logic conv_busy,
  input wire logic [3:0] mux_sel,
  output logic [11:0] core_result
);
  logic [11:0] code_r; // channel number in the top nibble
  // capture at start so a late mux change cannot alter the answer
  always_ff @(posedge ref_clk) begin
    if (conv_start) code_r <= {mux_sel, 8'ha5};
  end
  assign core_result = conv_busy ? code_r : ~code_r; // released bus
endmodule // sas_core_model

/* File: sas_sequencer_sva.sv */
// Purpose: port checker for the converter sequencer
// Assumes: one clock, synchronous reset
// Notes: exact length only where one conversion clock falls per cycle
`timescale 1ns/1ns
module sas_sequencer_sva
  import sas_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic module_on,
  input wire logic sample_ctl_set,
  input wire logic sample_ctl_clr,
  input wire logic [2:0] trigger_source_sel,
  input wire logic [3:0] ext_trig,
  input wire logic [5:0] conv_clock_div,
  input wire logic rc_clock_sel,
  input wire logic done_clr,
  input wire logic conv_start,
  input wire logic sample_ctl,
  input wire logic hold_sample,
  input wire logic conv_busy,
  input wire logic done,
  input wire logic conv_irq_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [9:0] busy_cnt_r; // cycles of the running conversion
  // cleared while idle, so an aborted run never adds to the next
  always_ff @(posedge ref_clk) begin
    if (rst || !conv_busy) busy_cnt_r <= 10'h0;
    else busy_cnt_r <= busy_cnt_r + 10'h1;
  end
  sequence s_sw_trig;
    module_on && sample_ctl && trigger_source_sel == TRIG_SW && sample_ctl_clr;
  endsequence
  sequence s_conv_go;
    conv_start && conv_busy && !sample_ctl && !hold_sample;
  endsequence
  property p_sample_ctl; module_on && sample_ctl_set && !sample_ctl && !conv_busy
    |=> sample_ctl && hold_sample; endproperty
  a_sample_ctl: assert property (p_sample_ctl) else $error("no sampling");
  property p_sw_trig; s_sw_trig |=> s_conv_go; endproperty
  a_sw_trig: assert property (p_sw_trig) else $error("no sw start");
  property p_ext; module_on && sample_ctl && trigger_source_sel == 3'h1 && ext_trig[1]
    |=> s_conv_go; endproperty
  a_ext: assert property (p_ext) else $error("no ext start");
  property p_cause; conv_start |-> $past(hold_sample) && $past(module_on); endproperty
  a_cause: assert property (p_cause) else $error("stray start");
  property p_len; $fell(conv_busy) && $past(module_on) && !$past(rst) && !rc_clock_sel
    |-> busy_cnt_r >= 10'he && (conv_clock_div > 6'h1 || busy_cnt_r == 10'he); endproperty
  a_len: assert property (p_len) else $error("bad length");
  property p_irq; $rose(conv_irq_flag) |-> done && $fell(conv_busy); endproperty
  a_irq: assert property (p_irq) else $error("stray irq");
  property p_hold; done && !done_clr |=> done; endproperty
  a_hold: assert property (p_hold) else $error("done lost");
  property p_abort; !module_on |=> !conv_busy && !conv_start && !sample_ctl; endproperty
  a_abort: assert property (p_abort) else $error("no abort");
endmodule // sas_sequencer_sva
bind sas_sequencer sas_sequencer_sva u_sas_sequencer_sva (.*);

/* File: test_sas_sequencer.sv */
// Purpose: directed bench for the converter sequencer
// Assumes: inputs move on the falling edge; the core model answers
// Notes: divider 1 gives one conversion clock per cycle
`timescale 1ns/1ns
module test_sas_sequencer;
  import sas_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, module_on = 1'b0, sample_ctl_set = 1'b0;
  logic sample_ctl_clr = 1'b0, auto_sample_enable = 1'b0, split_buffer_sel = 1'b0;
  logic alternate_mux_sel = 1'b0, rc_clock_sel = 1'b0, done_clr = 1'b0, irq_clr = 1'b0;
  logic rc_tick_pin = 1'b0;
  logic [2:0] trigger_source_sel = 3'h0;
  logic [3:0] ext_trig = 4'h0, first_input_set = 4'h9, second_input_set = 4'hc, rd_addr = 4'h0;
  logic [4:0] auto_sample_time = 5'h1; // one clock, the legal minimum
  logic [5:0] conv_clock_div = 6'h1;
  logic [1:0] output_format_sel = 2'h0;
  logic [15:0] control_reg_two = 16'h0, scan_select_reg = 16'h0124, rd_data;
  logic [RES_W-1:0] core_result;
  logic [3:0] mux_sel;
  logic hold_sample, conv_start, sample_ctl, conv_busy, done, conv_irq_flag, buf_half, h0;
  logic [15:0] fmt_exp [4] = '{16'h09a5, 16'hf9a5, 16'h9a50, 16'h9a50}; // code 9a5
  logic [5:0] div_tab [3] = '{6'h3, 6'h3f, 6'h1}; // last entry runs from rc
  // one tad of phase slack: the trigger does not wait for a tick
  int lo_t [3] = '{27, 417, 652};
  int hi_t [3] = '{28, 448, 706};
  int n_mismatch = 0;
  int checks_done = 0;
  int n;
  sas_sequencer u_sas_sequencer (.*);
  sas_core_model u_sas_core_model (.*);
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  // free-running rc source, 402 ns period keeps the rc tad legal
  // at 125 MHz even the largest divider gives 256 ns, so divided runs check timing only
  initial begin
    forever #201 rc_tick_pin = ~rc_tick_pin;
  end
  task automatic tk(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // integer read; the model puts the channel in the top nibble
  task automatic rd(input logic [3:0] a, input logic [3:0] ch);
    rd_addr = a;
    tk(2);
    check(rd_data, {4'h0, ch, 8'ha5});
  endtask
  // settings move only while the module is off, then flags are cleared
  task automatic cfg(input logic [2:0] tr, input logic [15:0] c2, input logic sp, al, as);
    module_on = 1'b0;
    tk(1);
    trigger_source_sel = tr;
    control_reg_two = c2;
    split_buffer_sel = sp;
    alternate_mux_sel = al;
    auto_sample_enable = as;
    {done_clr, irq_clr} = 2'h3;
    tk(1);
    {done_clr, irq_clr} = 2'h0;
    module_on = 1'b1;
    tk(1);
  endtask
  // one conversion; busy cycles land in n, module dropped after ab of them
  task automatic conv(input int ab);
    sample_ctl_set = 1'b1;
    tk(1);
    sample_ctl_set = 1'b0;
    tk(2);
    sample_ctl_clr = (trigger_source_sel == TRIG_SW);
    ext_trig = {trigger_source_sel == 3'h3, trigger_source_sel == 3'h2,
      trigger_source_sel == 3'h1, 1'b0};
    tk(1);
    sample_ctl_clr = 1'b0;
    ext_trig = 4'h0;
    n = 0;
    while (conv_busy === 1'b1 && n < 2000) begin
      n++;
      if (n == ab) module_on = 1'b0;
      tk(1);
    end
    if (n >= 2000) n_mismatch++; // a stuck conversion counts as a mismatch
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hang guard, far beyond the well under 2000 cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    conclude();
  end
  initial begin
    tk(10);
    rst = 1'b0;
    tk(1);
    cfg(TRIG_SW, 16'h0, 1'b0, 1'b0, 1'b0);
    conv(0);
    check(16'(n), 16'he);
    check({14'h0, done, conv_irq_flag}, 16'h3);
    for (int f = 0; f < 4; f++) begin
      output_format_sel = 2'(f);
      tk(2);
      check(rd_data, fmt_exp[f]);
    end
    output_format_sel = FMT_INT;
    $display("formats done");
    first_input_set = 4'h3;
    cfg(TRIG_SW, 16'h000c, 1'b0, 1'b1, 1'b0);
    repeat (3) conv(0);
    check({15'h0, done}, 16'h0);
    conv(0);
    check({14'h0, done, conv_irq_flag}, 16'h3);
    for (int i = 0; i < 4; i++) rd(4'(i), i[0] ? 4'hc : 4'h3);
    first_input_set = 4'h1;
    conv(0);
    rd(4'h0, 4'h1);
    $display("alternate done");
    cfg(TRIG_SW, 16'h0404, 1'b0, 1'b0, 1'b0);
    repeat (2) begin
      conv(0);
      conv(0);
      rd(4'h0, 4'h2);
      rd(4'h1, 4'h5);
    end
    $display("scan done");
    cfg(TRIG_SW, 16'h0, 1'b1, 1'b0, 1'b0);
    h0 = buf_half;
    for (int i = 1; i < 4; i++) begin
      first_input_set = 4'(i);
      conv(0);
      check({15'h0, buf_half}, {15'h0, h0 ^ i[0]});
    end
    rd({h0, 3'h0}, 4'h3);
    rd({~h0, 3'h0}, 4'h2);
    $display("split done");
    // each external source in turn
    for (int s = 1; s < 4; s++) begin
      first_input_set = 4'(s + 4);
      cfg(3'(s), 16'h0, 1'b0, 1'b0, 1'b0);
      conv(0);
      rd(4'h0, 4'(s + 4));
    end
    first_input_set = 4'h6;
    cfg(TRIG_AUTO, 16'h0004, 1'b0, 1'b0, 1'b1);
    n = 0;
    while (done !== 1'b1 && n < 500) begin
      n++;
      tk(1);
    end
    check({15'h0, done}, 16'h1);
    module_on = 1'b0;
    tk(2);
    check({14'h0, conv_busy, sample_ctl}, 16'h0);
    rd(4'h1, 4'h6);
    first_input_set = 4'h7;
    cfg(TRIG_SW, 16'h0, 1'b0, 1'b0, 1'b0);
    conv(5);
    check({14'h0, done, conv_busy}, 16'h0);
    rd(4'h0, 4'h6);
    $display("triggers done");
    for (int i = 0; i < 3; i++) begin
      module_on = 1'b0;
      tk(1);
      conv_clock_div = div_tab[i];
      rc_clock_sel = (i == 2);
      cfg(TRIG_SW, 16'h0, 1'b0, 1'b0, 1'b0);
      conv(0);
      check(16'(n >= lo_t[i] && n <= hi_t[i]), 16'h1);
    end
    $display("clocks done");
    conclude();
  end
endmodule // test_sas_sequencer
